// *** rtl/daj_pkg.sv ***
package daj_pkg;

   // Widths
   localparam int INSTR_W = 22;
   localparam int ACC_W   = 16;
   localparam int PTR_W   = 6;
   localparam int JADDR_W = 9;
   localparam int OPC_W   = 5;

   // Field positions of the instruction word
   localparam int OPC_HI      = 21;
   localparam int OPC_LO      = 17;
   localparam int BETA_X_BIT  = 16;
   localparam int ALPHA_Y_BIT = 15;
   localparam int FLOAT_BIT   = 14;
   localparam int ACCUMULATOR_B_BIT    = 13;
   localparam int WR_HOLD_BIT = 12;
   localparam int WR_EN_BIT   = 11;
   localparam int MODE_HI     = 10;
   localparam int MODE_LO     = 9;
   localparam int XPAGE_HI    = 8;
   localparam int XPAGE_LO    = 6;
   localparam int YPAGE_HI    = 5;
   localparam int YPAGE_LO    = 3;
   localparam int DADDR_HI    = 5;
   localparam int DADDR_LO    = 1;
   localparam int RAM_INC_BIT = 2;
   localparam int ROM_INC_BIT = 1;
   localparam int PTR_B_BIT   = 0;
   localparam int JRC_BIT     = 16;
   localparam int JCOND_HI    = 15;
   localparam int JCOND_LO    = 13;
   localparam int IMM_ACCUMULATOR_B_BIT = 16;
   localparam int IMM_SEL_HI  = 9;
   localparam int IMM_SEL_LO  = 8;
   localparam int IMM6_HI     = 15;
   localparam int IMM6_LO     = 10;

   // Opcode field values
   localparam logic [4:0] OPC_ADD   = 5'h00;
   localparam logic [4:0] OPC_SUB   = 5'h01;
   localparam logic [4:0] OPC_LOAD  = 5'h02;
   localparam logic [4:0] OPC_AND   = 5'h03;
   localparam logic [4:0] OPC_OR    = 5'h04;
   localparam logic [4:0] OPC_XOR   = 5'h05;
   localparam logic [4:0] OPC_ABS   = 5'h06;
   localparam logic [4:0] OPC_RPT   = 5'h07;
   localparam logic [4:0] OPC_NEG   = 5'h08;
   localparam logic [4:0] OPC_INC   = 5'h09;
   localparam logic [4:0] OPC_DEC   = 5'h0A;
   localparam logic [4:0] OPC_SHR   = 5'h0B;
   localparam logic [4:0] OPC_SHL   = 5'h0C;
   localparam logic [4:0] OPC_FLT   = 5'h0D;
   localparam logic [4:0] OPC_FIX   = 5'h0E;
   localparam logic [4:0] OPC_CLR   = 5'h0F;
   localparam logic [4:0] OPC_NOP   = 5'h10;
   localparam logic [4:0] OPC_SGY   = 5'h11;
   localparam logic [4:0] OPC_IMMA  = 5'h18;
   localparam logic [4:0] OPC_IMMP  = 5'h19;
   localparam logic [4:0] OPC_JFLAG = 5'h1C;
   localparam logic [4:0] OPC_JCNT  = 5'h1D;

   // Addressing modes in bits 10..9
   localparam logic [1:0] MODE_DIRECT = 2'h0;
   localparam logic [1:0] MODE_XY     = 2'h2;
   localparam logic [1:0] MODE_XG     = 2'h3;

   // Immediate pointer targets
   localparam logic [1:0] PSEL_RAM_A = 2'h0;
   localparam logic [1:0] PSEL_RAM_B = 2'h1;
   localparam logic [1:0] PSEL_ROM   = 2'h2;
   localparam logic [1:0] PSEL_RC    = 2'h3;

   // Exponent that the datapath loads on a float clear (minus eight)
   localparam logic [7:0] FCLR_EXP = 8'hF8;
   localparam logic [5:0] RC_ONE   = 6'h01;
   localparam logic [5:0] RC_ZERO  = 6'h00;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_ARM = 3'b010,
      ST_REP = 3'b100
   } daj_state_e;

   typedef enum logic [3:0] {
      AOP_NOP, AOP_ADD, AOP_SUB, AOP_LOAD, AOP_AND, AOP_OR, AOP_XOR, AOP_ABS,
      AOP_NEG, AOP_INC, AOP_DEC, AOP_SHR, AOP_SHL, AOP_FLT, AOP_FIX, AOP_CLR
   } daj_alu_op_e;

   typedef struct packed {
      daj_alu_op_e op;
      logic        acc_b;
      logic        float_mode;
      logic        alpha_y;
      logic        beta_x;
      logic        acc_we;
      logic        imm_load;
   } daj_alu_ctl_s;

   typedef struct packed {
      logic       direct;
      logic       gr_to_y;
      logic [2:0] x_page;
      logic [2:0] y_page;
      logic [5:0] daddr;
      logic       ram_we;
      logic       wr_hold;
      logic       ptr_b;
   } daj_mem_ctl_s;

   typedef struct packed {
      logic       ld_en;
      logic [1:0] ld_sel;
      logic [5:0] ld_val;
      logic       inc_ram;
      logic       ram_b;
      logic       inc_rom;
      logic       dec_rc;
   } daj_ptr_ctl_s;

   typedef struct packed {
      logic carry;
      logic neg;
      logic zero;
   } daj_flags_s;

endpackage

// *** rtl/daj_ptr_unit.sv ***
`timescale 1ns/10ps
`default_nettype none
module daj_ptr_unit
   import daj_pkg::*;
(
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         reset_n_i,
   // Update requests
   input  wire daj_ptr_ctl_s ctl_i,
   // Pointer and counter state
   output logic [PTR_W-1:0]  ram_ptr_a_o,
   output logic [PTR_W-1:0]  ram_ptr_b_o,
   output logic [PTR_W-1:0]  rom_ptr_o,
   output logic [PTR_W-1:0]  rpt_count_o
);

   logic [PTR_W-1:0] next_ram_a;
   logic [PTR_W-1:0] next_ram_b;
   logic [PTR_W-1:0] next_rom;
   logic [PTR_W-1:0] next_rc;

   function automatic logic [PTR_W-1:0] f_inc(input logic [PTR_W-1:0] p);
      return p + 6'h01;
   endfunction

   // Load wins over an auto-increment of the same pointer
   assign next_ram_a = (ctl_i.ld_en && ctl_i.ld_sel == PSEL_RAM_A) ? ctl_i.ld_val :
                       (ctl_i.inc_ram && !ctl_i.ram_b) ? f_inc(ram_ptr_a_o) : ram_ptr_a_o;
   assign next_ram_b = (ctl_i.ld_en && ctl_i.ld_sel == PSEL_RAM_B) ? ctl_i.ld_val :
                       (ctl_i.inc_ram && ctl_i.ram_b) ? f_inc(ram_ptr_b_o) : ram_ptr_b_o;
   assign next_rom   = (ctl_i.ld_en && ctl_i.ld_sel == PSEL_ROM) ? ctl_i.ld_val :
                       ctl_i.inc_rom ? f_inc(rom_ptr_o) : rom_ptr_o;

   // Counter stops at zero so repeat and loop jumps cannot wrap round
   assign next_rc = (ctl_i.ld_en && ctl_i.ld_sel == PSEL_RC) ? ctl_i.ld_val :
                    (ctl_i.dec_rc && rpt_count_o != RC_ZERO) ? rpt_count_o - RC_ONE : rpt_count_o;

   // State registers
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ram_ptr_a_o <= '0;
         ram_ptr_b_o <= '0;
         rom_ptr_o   <= '0;
         rpt_count_o <= '0;
      end else begin
         ram_ptr_a_o <= next_ram_a;
         ram_ptr_b_o <= next_ram_b;
         rom_ptr_o   <= next_rom;
         rpt_count_o <= next_rc;
      end
   end

endmodule
`default_nettype wire

// *** rtl/daj_alu_imm_jump_dec.sv ***
`timescale 1ns/10ps
`default_nettype none
module daj_alu_imm_jump_dec
   import daj_pkg::*;
(
   // Clock and reset
   input  wire logic               mclk_i,
   input  wire logic               reset_n_i,
   // Instruction from the sequencer
   input  wire logic               instr_valid_i,
   input  wire logic [INSTR_W-1:0] instr_i,
   // Datapath status
   input  wire daj_flags_s         flags_i,
   input  wire logic               y_sign_i,
   input  wire logic               acc_a_sign_i,
   input  wire logic               acc_b_sign_i,
   // ALU and memory control
   output daj_alu_ctl_s            alu_ctl_o,
   output daj_mem_ctl_s            mem_ctl_o,
   output logic [ACC_W-1:0]        imm_data_o,
   output logic                    mult_float_o,
   output logic                    product_valid_o,
   // Sequencer control
   output logic                    jump_o,
   output logic [JADDR_W-1:0]      jump_addr_o,
   output logic                    int_hold_o,
   output logic                    busy_o,
   // Pointers and repeat counter
   output logic [PTR_W-1:0]        ram_ptr_a_o,
   output logic [PTR_W-1:0]        ram_ptr_b_o,
   output logic [PTR_W-1:0]        rom_ptr_o,
   output logic [PTR_W-1:0]        rpt_count_o
);

   daj_state_e         state;
   daj_state_e         next_state;
   logic [INSTR_W-1:0] held_word;
   logic               rpt_float;
   daj_alu_ctl_s       next_alu;
   daj_mem_ctl_s       next_mem;
   daj_ptr_ctl_s       ptr_ctl;

   wire [INSTR_W-1:0] word;
   wire               issue;
   wire [OPC_W-1:0]   opc;
   wire               is_alu;
   wire               is_rpt;
   wire               page_mode;
   wire               direct;
   wire               acc_b;
   wire               sign_diff;
   wire               fixed_only;
   wire [2:0]         cond_hit;
   wire               jflag_taken;
   wire               jcnt_taken;
   wire               jump_taken;
   wire               rc_gt_one;
   wire               next_hold;
   daj_alu_op_e       op_dec;

   // Opcode to ALU action; the sign-match op picks negate or idle
   function automatic daj_alu_op_e f_alu_op(input logic [OPC_W-1:0] o, input logic flip);
      daj_alu_op_e r;
      r = AOP_NOP;
      case (o)
         OPC_ADD:  r = AOP_ADD;
         OPC_SUB:  r = AOP_SUB;
         OPC_LOAD: r = AOP_LOAD;
         OPC_AND:  r = AOP_AND;
         OPC_OR:   r = AOP_OR;
         OPC_XOR:  r = AOP_XOR;
         OPC_ABS:  r = AOP_ABS;
         OPC_NEG:  r = AOP_NEG;
         OPC_INC:  r = AOP_INC;
         OPC_DEC:  r = AOP_DEC;
         OPC_SHR:  r = AOP_SHR;
         OPC_SHL:  r = AOP_SHL;
         OPC_FLT:  r = AOP_FLT;
         OPC_FIX:  r = AOP_FIX;
         OPC_CLR:  r = AOP_CLR;
         OPC_SGY:  r = flip ? AOP_NEG : AOP_NOP;
         default:  r = AOP_NOP;
      endcase
      return r;
   endfunction

   // While repeating, the latched word is replayed and the input is ignored
   assign word  = (state == ST_REP) ? held_word : instr_i;
   assign issue = (state == ST_REP) || instr_valid_i;

   // Field decode
   assign opc        = word[OPC_HI:OPC_LO];
   assign is_alu     = opc <= OPC_SGY;
   assign is_rpt     = opc == OPC_RPT;
   assign page_mode  = word[MODE_HI];
   assign direct     = word[MODE_HI:MODE_LO] == MODE_DIRECT;
   assign acc_b      = word[ACCUMULATOR_B_BIT];
   assign sign_diff  = y_sign_i ^ (acc_b ? acc_b_sign_i : acc_a_sign_i);
   assign fixed_only = opc == OPC_AND || opc == OPC_OR || opc == OPC_XOR || opc == OPC_INC ||
                       opc == OPC_DEC || opc == OPC_SHR || opc == OPC_SHL;
   assign op_dec     = f_alu_op(opc, sign_diff);

   // Jump conditions; flags come straight from the condition register
   assign cond_hit    = word[JCOND_HI:JCOND_LO] & {flags_i.carry, flags_i.neg, flags_i.zero};
   assign jflag_taken = opc == OPC_JFLAG && ((|cond_hit) || word[JCOND_HI:JCOND_LO] == 3'h0);
   assign jcnt_taken  = opc == OPC_JCNT && rpt_count_o != RC_ZERO;
   assign jump_taken  = issue && (jflag_taken || jcnt_taken);
   assign rc_gt_one   = rpt_count_o > RC_ONE;

   // ALU control for this instruction, all fields in one go
   always_comb begin
      next_alu            = '0;
      next_alu.op         = AOP_NOP;
      next_alu.acc_b      = acc_b;
      next_alu.float_mode = word[FLOAT_BIT] && !fixed_only;
      next_alu.alpha_y    = word[ALPHA_Y_BIT];
      next_alu.beta_x     = word[BETA_X_BIT]; // X-bus holds the accumulator in direct mode
      if (issue && is_alu) begin
         next_alu.op     = op_dec;
         next_alu.acc_we = op_dec != AOP_NOP;
      end else if (issue && opc == OPC_IMMA) begin
         next_alu.acc_b    = word[IMM_ACCUMULATOR_B_BIT];
         next_alu.acc_we   = 1'b1;
         next_alu.imm_load = 1'b1;
         next_alu.float_mode = 1'b0;
      end
   end

   // Memory addressing and write control
   always_comb begin
      next_mem         = '0;
      next_mem.direct  = direct;
      next_mem.gr_to_y = word[MODE_HI:MODE_LO] == MODE_XG;
      next_mem.x_page  = word[XPAGE_HI:XPAGE_LO];
      next_mem.y_page  = word[YPAGE_HI:YPAGE_LO];
      next_mem.daddr   = {1'b0, word[DADDR_HI:DADDR_LO]};
      next_mem.ptr_b   = word[PTR_B_BIT];
      next_mem.wr_hold = word[WR_HOLD_BIT];
      next_mem.ram_we  = issue && is_alu && word[WR_EN_BIT];
   end

   // Pointer and counter requests
   always_comb begin
      ptr_ctl         = '0;
      ptr_ctl.ld_en   = issue && opc == OPC_IMMP;
      ptr_ctl.ld_sel  = word[IMM_SEL_HI:IMM_SEL_LO];
      ptr_ctl.ld_val  = word[IMM6_HI:IMM6_LO];
      ptr_ctl.ram_b   = word[PTR_B_BIT];
      ptr_ctl.inc_ram = issue && is_alu && page_mode && word[RAM_INC_BIT];
      ptr_ctl.inc_rom = issue && is_alu && page_mode && word[ROM_INC_BIT];
      ptr_ctl.dec_rc  = issue && ((is_alu && page_mode && (word[RAM_INC_BIT] || word[ROM_INC_BIT])) ||
                                  (opc == OPC_JCNT && word[JRC_BIT]) ||
                                  state != ST_RUN);
   end

   // Repeat sequencing: arm on the repeat op, replay while passes remain
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: if (issue && is_rpt) begin
            next_state = ST_ARM;
         end
         ST_ARM: if (instr_valid_i) begin
            next_state = rc_gt_one ? ST_REP : ST_RUN;
         end
         ST_REP: if (!rc_gt_one) begin
            next_state = ST_RUN;
         end
         default: next_state = ST_RUN;
      endcase
   end

   // Hold interrupts from the repeat op to the last replayed pass
   assign next_hold = next_state != ST_RUN || state != ST_RUN || jump_taken;

   // State and latched repeat word
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state     <= ST_RUN;
         held_word <= '0;
         rpt_float <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_ARM && instr_valid_i) begin
            held_word <= instr_i;
         end
         if (state == ST_RUN && issue && is_rpt) begin
            rpt_float <= word[FLOAT_BIT];
         end
      end
   end

   // Registered control outputs
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         alu_ctl_o       <= '0;
         mem_ctl_o       <= '0;
         imm_data_o      <= '0;
         mult_float_o    <= 1'b0;
         product_valid_o <= 1'b0;
         jump_o          <= 1'b0;
         jump_addr_o     <= '0;
         int_hold_o      <= 1'b0;
         busy_o          <= 1'b0;
      end else begin
         alu_ctl_o       <= next_alu;
         mem_ctl_o       <= next_mem;
         imm_data_o      <= word[ACC_W-1:0];
         mult_float_o    <= (state != ST_RUN) ? rpt_float : word[FLOAT_BIT];
         product_valid_o <= issue;
         jump_o          <= jump_taken;
         jump_addr_o     <= word[JADDR_W-1:0];
         int_hold_o      <= next_hold;
         busy_o          <= next_state == ST_REP;
      end
   end

   // Pointers and counter
   daj_ptr_unit u_ptr (
      .mclk_i      (mclk_i),
      .reset_n_i   (reset_n_i),
      .ctl_i       (ptr_ctl),
      .ram_ptr_a_o (ram_ptr_a_o),
      .ram_ptr_b_o (ram_ptr_b_o),
      .rom_ptr_o   (rom_ptr_o),
      .rpt_count_o (rpt_count_o)
   );

   // Checks on the decoded behaviour
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!reset_n_i);

   AST_JMP_UNCOND: assert property (
      instr_valid_i && state == ST_RUN && opc == OPC_JFLAG && instr_i[JCOND_HI:JCOND_LO] == 3'h0
      |=> jump_o && jump_addr_o == $past(instr_i[JADDR_W-1:0]))
      else $error("unconditional jump not taken");
   AST_JMP_CNT_DEC: assert property (
      instr_valid_i && state == ST_RUN && opc == OPC_JCNT && instr_i[JRC_BIT] && rpt_count_o != RC_ZERO
      |=> jump_o && rpt_count_o == $past(rpt_count_o) - RC_ONE)
      else $error("counter jump did not decrement");
   AST_IMM_ACC: assert property (
      instr_valid_i && state == ST_RUN && opc == OPC_IMMA
      |=> alu_ctl_o.imm_load && alu_ctl_o.acc_we && imm_data_o == $past(instr_i[ACC_W-1:0]))
      else $error("immediate accumulator load lost");
   AST_IMM_RC: assert property (
      instr_valid_i && state == ST_RUN && opc == OPC_IMMP && instr_i[IMM_SEL_HI:IMM_SEL_LO] == PSEL_RC
      |=> rpt_count_o == $past(instr_i[IMM6_HI:IMM6_LO]))
      else $error("counter immediate load lost");
   AST_INC_FIXED: assert property (
      alu_ctl_o.op == AOP_INC || alu_ctl_o.op == AOP_DEC |-> !alu_ctl_o.float_mode)
      else $error("inc or dec in float mode");
   AST_RPT_HOLD: assert property (
      busy_o |-> int_hold_o ##1 int_hold_o)
      else $error("interrupt hold dropped during repeat");
   AST_BUS_SEL: assert property (
      instr_valid_i && state == ST_RUN && is_alu && page_mode
      |=> alu_ctl_o.alpha_y == $past(instr_i[ALPHA_Y_BIT]) && alu_ctl_o.beta_x == $past(instr_i[BETA_X_BIT]))
      else $error("ALU input selection wrong");
   AST_RC_AUTODEC: assert property (
      instr_valid_i && state == ST_RUN && is_alu && !is_rpt && page_mode && rpt_count_o != RC_ZERO &&
      (instr_i[RAM_INC_BIT] || instr_i[ROM_INC_BIT])
      |=> rpt_count_o == $past(rpt_count_o) - RC_ONE)
      else $error("counter auto decrement missing");
   AST_SGY_NEG: assert property (
      instr_valid_i && state == ST_RUN && opc == OPC_SGY && sign_diff
      |=> alu_ctl_o.op == AOP_NEG && alu_ctl_o.acc_we)
      else $error("sign-match op did not negate");
   AST_PROD: assert property (
      instr_valid_i |=> product_valid_o)
      else $error("product not flagged");

   COV_REPEAT: cover property (state == ST_ARM ##1 state == ST_REP ##[1:8] state == ST_RUN);
   COV_CNT_JUMP: cover property (issue && jcnt_taken ##1 jump_o);
   COV_IMM_PTR: cover property (issue && opc == OPC_IMMP);

endmodule
`default_nettype wire

// *** verif/dsp_alu_immediate_jump_decode_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module dsp_alu_immediate_jump_decode_bench
   import daj_pkg::*;
;
   // Stimulus and observed ports
   logic               mclk_i = 1'b0;
   logic               reset_n_i = 1'b0;
   logic               valid = 1'b0;
   logic [INSTR_W-1:0] instr = '0;
   daj_flags_s         flags = '0;
   logic               ysg = 1'b0;
   logic               sa = 1'b0;
   logic               sb = 1'b0;
   daj_alu_ctl_s       alu;
   daj_mem_ctl_s       mem;
   logic [ACC_W-1:0]   imm;
   logic               mf, pv, jmp, ih, busy;
   logic [JADDR_W-1:0] ja;
   logic [PTR_W-1:0]   pa, pb, ro, rc;
   // Reference pointer and counter state
   logic [PTR_W-1:0]   ma = '0, mb = '0, mr = '0, mc = '0;
   int                 errors = 0;
   int                 cmp_count = 0;

   // 40 MHz clock
   always #12.5 mclk_i = ~mclk_i;

   daj_alu_imm_jump_dec uut (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .instr_valid_i(valid), .instr_i(instr),
      .flags_i(flags), .y_sign_i(ysg), .acc_a_sign_i(sa), .acc_b_sign_i(sb),
      .alu_ctl_o(alu), .mem_ctl_o(mem), .imm_data_o(imm), .mult_float_o(mf),
      .product_valid_o(pv), .jump_o(jmp), .jump_addr_o(ja), .int_hold_o(ih), .busy_o(busy),
      .ram_ptr_a_o(pa), .ram_ptr_b_o(pb), .rom_ptr_o(ro), .rpt_count_o(rc));

   // Four-state compare so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Offer a word at the falling edge; results are settled one falling edge later
   task automatic issue(input logic [INSTR_W-1:0] w);
      instr = w;
      valid = 1'b1;
      @(negedge mclk_i);
   endtask

   task automatic chk_ptrs;
      chk(pa, ma);
      chk(pb, mb);
      chk(ro, mr);
      chk(rc, mc);
   endtask

   // Pointer load through the immediate format; counter target also reloads model
   task automatic load_ptr(input logic [1:0] s, input logic [5:0] v);
      issue({OPC_IMMP, 1'b0, v, s, 8'h00});
      case (s)
         PSEL_RAM_A: ma = v;
         PSEL_RAM_B: mb = v;
         PSEL_ROM: mr = v;
         default: mc = v;
      endcase
      chk_ptrs();
   endtask

   // One random ALU instruction; mode 01 is avoided since its reading is a local choice
   task automatic do_alu(input logic [4:0] opc);
      logic [16:0] r;
      logic [3:0]  eo;
      logic        sel_s;
      r = 17'($urandom);
      if (r[10:9] == 2'h1)
         r[9] = 1'b0;
      {ysg, sa, sb} = 3'($urandom);
      sel_s = r[13] ? sb : sa;
      issue({opc, r});
      if (opc == OPC_NOP)
         eo = AOP_NOP;
      else if (opc == OPC_SGY)
         eo = (ysg != sel_s) ? AOP_NEG : AOP_NOP;
      else
         eo = (opc < 5'h07) ? 4'(opc + 5'h01) : opc[3:0];
      chk(alu.op, eo);
      chk(alu.acc_we, eo != AOP_NOP);
      chk(alu.acc_b, r[13]);
      chk(alu.float_mode, r[14] & !(opc inside {5'h03, 5'h04, 5'h05, 5'h09, 5'h0A, 5'h0B, 5'h0C}));
      chk({alu.beta_x, alu.alpha_y}, r[16:15]);
      chk(mem.ram_we, r[11]);
      chk(mem.wr_hold, r[12]);
      chk(mem.direct, r[10:9] == MODE_DIRECT);
      chk(mem.gr_to_y, r[10:9] == MODE_XG);
      if (r[10:9] == MODE_DIRECT) begin
         chk(mem.daddr, {1'b0, r[5:1]});
         chk(mem.x_page, r[8:6]);
      end else
         chk({mem.x_page, mem.y_page, mem.ptr_b}, {r[8:3], r[0]});
      chk(pv, 1'b1);
      chk(mf, r[14]);
      // Steps land in the same cycle as the decode
      if (r[10:9] != MODE_DIRECT) begin
         if (r[2] && r[0])
            mb++;
         else if (r[2])
            ma++;
         if (r[1])
            mr++;
         if ((r[2] | r[1]) && mc != 6'h00)
            mc--;
      end
      chk_ptrs();
   endtask

   initial begin
      logic [15:0] d;
      logic [8:0]  a;
      logic        t;
      int          n;
      void'($urandom(17));
      repeat (3) @(negedge mclk_i);
      reset_n_i = 1'b1;
      @(negedge mclk_i);
      chk({alu, jmp, busy, ih, rc}, '0);
      // Immediate accumulator loads, both targets
      for (int i = 0; i < 4; i++) begin
         d = 16'($urandom);
         issue({OPC_IMMA, i[0], d});
         chk({alu.imm_load, alu.acc_we, alu.acc_b}, {2'b11, i[0]});
         chk(imm, d);
      end
      for (int s = 0; s < 4; s++)
         load_ptr(s[1:0], 6'($urandom));
      load_ptr(PSEL_RC, 6'h3F);
      // Random ALU stream, back to back, every opcode but repeat
      for (int i = 0; i < 300; i++) begin
         n = $urandom_range(0, 16);
         do_alu(5'(n >= 7 ? n + 1 : n));
      end
      // Flag jumps, every mask including the unconditional one
      for (int m = 0; m < 8; m++) begin
         flags = daj_flags_s'(3'($urandom));
         a = 9'($urandom);
         issue({OPC_JFLAG, 1'b0, 3'(m), 4'h0, a});
         t = (m == 0) || ((3'(m) & flags) != 3'h0);
         chk(jmp, t);
         chk(ih, t);
         if (t)
            chk(ja, a);
      end
      // Counter jumps down through zero, with and without the decrement
      load_ptr(PSEL_RC, 6'h02);
      for (int i = 0; i < 6; i++) begin
         a = 9'($urandom);
         issue({OPC_JCNT, i[0], 7'h00, a});
         chk(jmp, mc != 6'h00);
         if (i[0] && mc != 6'h00)
            mc--;
         chk(rc, mc);
      end
      // Float repeat of a logic op with three passes
      load_ptr(PSEL_RC, 6'h03);
      issue({OPC_RPT, 3'b001, 14'h0000});
      chk(ih, 1'b1);
      issue({OPC_AND, 17'h00000});
      valid = 1'b0;
      n = 0;
      for (int k = 0; k < 8; k++) begin
         if (alu.op === AOP_AND) begin
            n++;
            chk(ih, 1'b1);
            chk(mf, 1'b1);
         end
         @(negedge mclk_i);
      end
      chk(n, 3);
      chk(rc, 6'h00);
      chk(busy, 1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
